/* verilog/cpuc_pkg.sv */
// Purpose: shared constants, types and field layouts of the cpu core
// Assumes: 16-bit instruction words and 16-bit data addresses
// Notes:   instruction encoding is local to this core
package cpuc_pkg;
	// ****************************************
	// instruction classes, bits 15:12
	// ****************************************
	localparam logic [3:0] OP_MUL   = 4'h7;
	localparam logic [3:0] OP_MULF  = 4'h8;
	localparam logic [3:0] OP_SUBI  = 4'h9;
	localparam logic [3:0] OP_ANDI  = 4'hA;
	localparam logic [3:0] OP_IO    = 4'hB;
	localparam logic [3:0] OP_LDI   = 4'hC;
	localparam logic [3:0] OP_ONE   = 4'hD;
	localparam logic [3:0] OP_WORD  = 4'hE;
	localparam logic [3:0] OP_MISC  = 4'hF;
	localparam logic [1:0] MS_LD    = 2'h0;
	localparam logic [1:0] MS_ST    = 2'h1;
	localparam logic [1:0] MS_SPM   = 2'h2;
	localparam logic [1:0] MS_BIT   = 2'h3;
	// ****************************************
	// register indexes and data space map
	// ****************************************
	localparam logic [4:0]  RI_X        = 5'h1A;
	localparam logic [4:0]  RI_WORD     = 5'h18;
	localparam logic [15:0] IO_DIR_END  = 16'h003F;
	localparam logic [15:0] EXT_IO_BASE = 16'h0040;
	localparam logic [15:0] IO_END      = 16'h0FFF;
	localparam logic [15:0] EE_BASE     = 16'h1000;
	localparam logic [15:0] EE_END      = 16'h1FFF;
	localparam logic [15:0] SRAM_BASE   = 16'h2000;
	localparam logic [15:0] TBL_START_DEF  = 16'hE000;
	localparam logic [15:0] BOOT_START_DEF = 16'hF000;
	localparam logic [15:0] PC_RST      = 16'h0000;
	localparam logic [7:0]  SREG_RST    = 8'h00;
	localparam int FL_C = 0;
	localparam int FL_Z = 1;
	localparam int FL_N = 2;
	localparam int FL_V = 3;
	localparam int FL_S = 4;
	localparam int FL_H = 5;
	localparam int MUL_CYCLES = 2;
	// ****************************************
	// types
	// ****************************************
	typedef enum logic [3:0] {ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC, ALU_AND, ALU_OR, ALU_EOR, ALU_MOV,
		ALU_COM, ALU_NEG, ALU_INC, ALU_DEC, ALU_LSR, ALU_ASR, ALU_ROR, ALU_SWAP} cpuc_alu_e;
	typedef enum logic [1:0] {MUL_UU, MUL_SS, MUL_SU} cpuc_mul_e;
	typedef struct packed {logic [15:0] addr; logic [7:0] wdata; logic re; logic we;} cpuc_dbus_s;
	typedef struct packed {logic direct_io; logic ext_io; logic eeprom; logic sram;} cpuc_region_s;
	typedef struct packed {logic h; logic s; logic v; logic n; logic z; logic c;} cpuc_flags_s;
	typedef struct packed {logic app_wr; logic app_rw; logic tbl_wr; logic tbl_rw;
		logic boot_wr; logic boot_rw;} cpuc_lock_s;
	typedef struct packed {logic we; logic [15:0] addr; logic [15:0] data;} cpuc_spm_s;
endpackage

/* verilog/cpuc_alu.sv */
// Purpose: 8-bit arithmetic, logic and shift unit with flag outputs
// Assumes: purely combinational
// Notes:   carry that an operation leaves alone passes c_in through; v otherwise reads 0
`timescale 1ns/10ps
module cpuc_alu (
	input  wire cpuc_pkg::cpuc_alu_e   fn,
	input  wire logic [7:0]            a,
	input  wire logic [7:0]            b,
	input  wire logic                  c_in,
	output logic [7:0]                 res,
	output cpuc_pkg::cpuc_flags_s      flg
);
	logic [8:0] s;
	logic       c;
	logic       v;
	always_comb
	begin
		s = 9'h000;
		res = a;
		c = c_in;
		v = 1'b0;
		unique case (fn)
			cpuc_pkg::ALU_ADD, cpuc_pkg::ALU_ADC:
			begin
				s = {1'b0, a} + {1'b0, b} + {8'h00, c_in & (fn == cpuc_pkg::ALU_ADC)};
				res = s[7:0];
				c = s[8];
				v = (a[7] == b[7]) && (res[7] != a[7]);
			end
			cpuc_pkg::ALU_SUB, cpuc_pkg::ALU_SBC:
			begin
				s = {1'b0, a} - {1'b0, b} - {8'h00, c_in & (fn == cpuc_pkg::ALU_SBC)};
				res = s[7:0];
				c = s[8];
				v = (a[7] != b[7]) && (res[7] != a[7]);
			end
			cpuc_pkg::ALU_AND:  res = a & b;
			cpuc_pkg::ALU_OR:   res = a | b;
			cpuc_pkg::ALU_EOR:  res = a ^ b;
			cpuc_pkg::ALU_MOV:  res = b;
			cpuc_pkg::ALU_COM:
			begin
				res = ~a;
				c = 1'b1;
			end
			cpuc_pkg::ALU_NEG:
			begin
				res = 8'h00 - a;
				c = (a != 8'h00);
				v = (a == 8'h80);
			end
			cpuc_pkg::ALU_INC:
			begin
				res = a + 8'h01;
				v = (a == 8'h7F);
			end
			cpuc_pkg::ALU_DEC:
			begin
				res = a - 8'h01;
				v = (a == 8'h80);
			end
			cpuc_pkg::ALU_LSR, cpuc_pkg::ALU_ASR, cpuc_pkg::ALU_ROR:
			begin
				res = {(fn == cpuc_pkg::ALU_ASR) ? a[7] : ((fn == cpuc_pkg::ALU_ROR) & c_in), a[7:1]};
				c = a[0];
				v = a[0] ^ res[7];
			end
			cpuc_pkg::ALU_SWAP: res = {a[3:0], a[7:4]};
		endcase
		flg.h = a[4] ^ b[4] ^ res[4];
		flg.s = res[7] ^ v;
		flg.v = v;
		flg.n = res[7];
		flg.z = (res == 8'h00);
		flg.c = c;
	end
endmodule

/* verilog/cpuc_mul.sv */
// Purpose: two-cycle 8x8 multiplier, integer and fractional forms
// Assumes: start is a one-cycle pulse; product valid while busy
// Notes:   carry is product bit 15 before the fractional shift
`timescale 1ns/10ps
module cpuc_mul (
	input  wire logic                  sys_clk,
	input  wire logic                  rst,
	input  wire logic                  start,
	input  wire logic [7:0]            a,
	input  wire logic [7:0]            b,
	input  wire cpuc_pkg::cpuc_mul_e   kind,
	input  wire logic                  frac,
	output logic [15:0]                prod,
	output logic                       c,
	output logic                       busy
);
	logic [7:0]          a_ff;
	logic [7:0]          b_ff;
	cpuc_pkg::cpuc_mul_e kind_ff;
	logic                frac_ff;
	logic [17:0]         full;
	always_ff @(posedge sys_clk)
	begin
		busy <= rst ? 1'b0 : start;
		if (start)
		begin
			a_ff <= a;
			b_ff <= b;
			kind_ff <= kind;
			frac_ff <= frac;
		end
	end
	always_comb
	begin
		full = 18'($signed({(kind_ff != cpuc_pkg::MUL_UU) & a_ff[7], a_ff})
			* $signed({(kind_ff == cpuc_pkg::MUL_SS) & b_ff[7], b_ff}));
		c = full[15];
		prod = frac_ff ? {full[14:0], 1'b0} : full[15:0];
	end
	chk_mul_uint_prod: assert property (@(posedge sys_clk) disable iff (rst)
		start && !frac && kind == cpuc_pkg::MUL_UU |=> prod == 16'({8'h00, $past(a)} * {8'h00, $past(b)}))
		else $error("unsigned integer product wrong");
	chk_mul_frac_sign: assert property (@(posedge sys_clk) disable iff (rst)
		start && frac && kind == cpuc_pkg::MUL_SS |=> prod == 16'(($signed($past(a)) * $signed($past(b))) <<< 1))
		else $error("signed fractional product wrong");
endmodule

/* verilog/cpuc_core.sv */
// Purpose: pipelined 8-bit cpu execution core with register file,
//          alu, multiplier hookup and data space decode
// Assumes: program memory answers pm_addr in the same cycle;
//          data memory answers a read in the cycle the request shows
// Notes:   program flow and interrupts are handled elsewhere
// Operation
// - fetch next instruction while current one executes
// - separate program and data buses
// - register-register, register-immediate and single-register ops
// - single-cycle arithmetic written back to register file
// - status flags updated after alu operations other than mov and swap
// - thirty-two 8-bit single-cycle working registers
// - four register pairs (r27:r26, r29:r28, r31:r30, r1:r0) act as 16-bit pointers
// - arithmetic, logic, bit groups; 8/16-bit arithmetic
// - i/o registers within lowest 4KB data space
// - first 64 i/o locations direct and mapped
// - extended i/o only via data loads/stores
// - 0x1000-0x1FFF reserved for mapped eeprom
// - sram decoded from address 0x2000
// - instructions fetched only from program memory
// - program store works only from boot section
// - independent locks per application, boot, table section
// - multiplier makes 16-bit product of 8-bit operands
// - unsigned, signed, mixed; integer and fractional
// - every multiply takes two clock cycles
`timescale 1ns/10ps
module cpuc_core #(
	parameter logic [15:0] TBL_START  = cpuc_pkg::TBL_START_DEF,
	parameter logic [15:0] BOOT_START = cpuc_pkg::BOOT_START_DEF
)(
	input  wire logic                  sys_clk,
	input  wire logic                  rst,
	output logic [15:0]                pm_addr,
	input  wire logic [15:0]           pm_rdata,
	output cpuc_pkg::cpuc_dbus_s       dbus,
	output cpuc_pkg::cpuc_region_s     region,
	input  wire logic [7:0]            dm_rdata,
	input  wire cpuc_pkg::cpuc_lock_s  lock,
	output cpuc_pkg::cpuc_spm_s        store_program_memory_instr,
	output logic                       spm_denied,
	output logic [7:0]                 sreg,
	output logic                       insn_done
);
	// ****************************************
	// state
	// ****************************************
	logic [7:0]                rf_ff [32];
	logic [15:0]               pc_ff;
	logic [15:0]               ir_ff;
	logic [15:0]               ir_pc_ff;
	logic                      ir_vld_ff;
	logic                      mul_ph_ff;
	logic                      ld_ph_ff;
	cpuc_pkg::cpuc_dbus_s      dbus_ff;
	cpuc_pkg::cpuc_spm_s       spm_ff;
	logic                      den_ff;
	logic [7:0]                sreg_ff;
	// ****************************************
	// decode
	// ****************************************
	logic [3:0]                op;
	logic [1:0]                sub;
	logic [4:0]                rd;
	logic [4:0]                rr;
	logic [4:0]                rdi;
	logic [4:0]                io_rd;
	logic [4:0]                pt;
	logic [4:0]                pr;
	logic                      is_rr;
	logic                      is_imm;
	logic                      is_mul;
	logic                      is_misc;
	logic                      is_word;
	logic                      ld_issue;
	logic                      st_issue;
	logic                      stall;
	logic [15:0]               pval;
	logic [15:0]               wval;
	logic [16:0]               wres;
	logic [15:0]               zval;
	logic                      in_boot;
	logic                      tgt_lock;
	assign op = ir_ff[15:12];
	assign sub = ir_ff[11:10];
	assign rd = ir_ff[9:5];
	assign rr = ir_ff[4:0];
	assign rdi = {1'b1, ir_ff[11:8]};
	assign io_rd = ir_ff[10:6];
	assign pt = cpuc_pkg::RI_X + {2'b00, ir_ff[1:0], 1'b0};
	assign pr = cpuc_pkg::RI_WORD + {2'b00, ir_ff[7:6], 1'b0};
	assign is_rr = ir_vld_ff && op < cpuc_pkg::OP_MUL;
	assign is_imm = ir_vld_ff && (op == cpuc_pkg::OP_SUBI || op == cpuc_pkg::OP_ANDI || op == cpuc_pkg::OP_LDI);
	assign is_mul = ir_vld_ff && (op == cpuc_pkg::OP_MUL || op == cpuc_pkg::OP_MULF);
	assign is_misc = ir_vld_ff && op == cpuc_pkg::OP_MISC;
	assign is_word = ir_vld_ff && op == cpuc_pkg::OP_WORD;
	// direct i/o form carries only six address bits
	assign ld_issue = (is_misc && sub == cpuc_pkg::MS_LD) || (ir_vld_ff && op == cpuc_pkg::OP_IO && !ir_ff[11]);
	assign st_issue = (is_misc && sub == cpuc_pkg::MS_ST) || (ir_vld_ff && op == cpuc_pkg::OP_IO && ir_ff[11]);
	assign stall = (is_mul && !mul_ph_ff) || (ld_issue && !ld_ph_ff);
	assign pval = {rf_ff[pt + 5'h01], rf_ff[pt]};
	assign wval = {rf_ff[pr + 5'h01], rf_ff[pr]};
	assign zval = {rf_ff[5'h1F], rf_ff[5'h1E]};
	assign wres = ir_ff[8] ? {1'b0, wval} - {11'h000, ir_ff[5:0]} : {1'b0, wval} + {11'h000, ir_ff[5:0]};
	// ****************************************
	// alu operand select
	// ****************************************
	cpuc_pkg::cpuc_alu_e       alu_fn;
	logic [7:0]                alu_a;
	logic [7:0]                alu_b;
	logic [4:0]                alu_rd;
	logic                      alu_en;
	logic                      flag_upd;
	logic [7:0]                alu_res;
	cpuc_pkg::cpuc_flags_s     alu_flg;
	always_comb
	begin
		alu_fn = cpuc_pkg::ALU_MOV;
		alu_rd = rd;
		alu_a = rf_ff[rd];
		alu_b = rf_ff[rr];
		alu_en = 1'b0;
		if (is_rr)
		begin
			alu_fn = cpuc_pkg::cpuc_alu_e'(op);
			alu_en = 1'b1;
		end
		else if (is_imm)
		begin
			alu_rd = rdi;
			alu_a = rf_ff[rdi];
			alu_b = ir_ff[7:0];
			alu_en = 1'b1;
			if (op == cpuc_pkg::OP_SUBI)
				alu_fn = cpuc_pkg::ALU_SUB;
			else if (op == cpuc_pkg::OP_ANDI)
				alu_fn = cpuc_pkg::ALU_AND;
		end
		else if (ir_vld_ff && op == cpuc_pkg::OP_ONE)
		begin
			alu_fn = cpuc_pkg::cpuc_alu_e'({1'b1, ir_ff[2:0]});
			alu_en = 1'b1;
		end
		flag_upd = alu_en && alu_fn != cpuc_pkg::ALU_MOV && alu_fn != cpuc_pkg::ALU_SWAP;
	end
	cpuc_alu u_alu (
		.fn   (alu_fn),
		.a    (alu_a),
		.b    (alu_b),
		.c_in (sreg_ff[cpuc_pkg::FL_C]),
		.res  (alu_res),
		.flg  (alu_flg)
	);
	// ****************************************
	// multiplier
	// ****************************************
	logic [15:0]               mul_prod;
	logic                      mul_c;
	logic                      mul_busy;
	cpuc_mul u_mul (
		.sys_clk (sys_clk),
		.rst     (rst),
		.start   (is_mul && !mul_ph_ff),
		.a       (rf_ff[rd]),
		.b       (rf_ff[rr]),
		.kind    (cpuc_pkg::cpuc_mul_e'(sub)),
		.frac    (op == cpuc_pkg::OP_MULF),
		.prod    (mul_prod),
		.c       (mul_c),
		.busy    (mul_busy)
	);
	// ****************************************
	// fetch pipeline
	// ****************************************
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			pc_ff <= cpuc_pkg::PC_RST;
			ir_ff <= 16'h0000;
			ir_pc_ff <= cpuc_pkg::PC_RST;
			ir_vld_ff <= 1'b0;
		end
		else if (!stall)
		begin
			pc_ff <= pc_ff + 16'h0001;
			ir_ff <= pm_rdata;
			ir_pc_ff <= pc_ff;
			ir_vld_ff <= 1'b1;
		end
	end
	always_ff @(posedge sys_clk)
	begin
		mul_ph_ff <= !rst && is_mul && !mul_ph_ff;
		ld_ph_ff <= !rst && ld_issue && !ld_ph_ff;
	end
	assign pm_addr = pc_ff;
	assign insn_done = ir_vld_ff && !stall;
	// ****************************************
	// register file
	// ****************************************
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			for (int i = 0; i < 32; i++)
				rf_ff[i] <= 8'h00;
		end
		else
		begin
			if (alu_en)
				rf_ff[alu_rd] <= alu_res;
			if (mul_ph_ff)
			begin
				rf_ff[5'h00] <= mul_prod[7:0];
				rf_ff[5'h01] <= mul_prod[15:8];
			end
			if (is_word)
			begin
				rf_ff[pr] <= wres[7:0];
				rf_ff[pr + 5'h01] <= wres[15:8];
			end
			if (is_misc && sub == cpuc_pkg::MS_BIT)
				rf_ff[rd][ir_ff[2:0]] <= ir_ff[3];
			if ((ld_issue && !ld_ph_ff || st_issue) && is_misc && ir_ff[2])
			begin
				rf_ff[pt] <= pval[7:0] + 8'h01;
				rf_ff[pt + 5'h01] <= pval[15:8] + {7'h00, pval[7:0] == 8'hFF};
			end
			if (ld_ph_ff)
				rf_ff[is_misc ? rd : io_rd] <= dm_rdata;
		end
	end
	// ****************************************
	// status flags
	// ****************************************
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			sreg_ff <= cpuc_pkg::SREG_RST;
		else if (flag_upd)
			sreg_ff[5:0] <= alu_flg;
		else if (mul_ph_ff)
		begin
			sreg_ff[cpuc_pkg::FL_C] <= mul_c;
			sreg_ff[cpuc_pkg::FL_Z] <= (mul_prod == 16'h0000);
		end
		else if (is_word)
		begin
			sreg_ff[cpuc_pkg::FL_C] <= wres[16];
			sreg_ff[cpuc_pkg::FL_Z] <= (wres[15:0] == 16'h0000);
			sreg_ff[cpuc_pkg::FL_N] <= wres[15];
			sreg_ff[cpuc_pkg::FL_V] <= ir_ff[8] ? wval[15] & ~wres[15] : ~wval[15] & wres[15];
			sreg_ff[cpuc_pkg::FL_S] <= wres[15] ^ (ir_ff[8] ? wval[15] & ~wres[15] : ~wval[15] & wres[15]);
		end
	end
	assign sreg = sreg_ff;
	// ****************************************
	// data bus requests
	// ****************************************
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			dbus_ff <= '0;
		else
		begin
			dbus_ff.re <= 1'b0;
			dbus_ff.we <= 1'b0;
			if (ld_issue && !ld_ph_ff)
			begin
				dbus_ff.addr <= is_misc ? pval : {10'h000, ir_ff[5:0]};
				dbus_ff.re <= 1'b1;
			end
			else if (st_issue)
			begin
				dbus_ff.addr <= is_misc ? pval : {10'h000, ir_ff[5:0]};
				dbus_ff.wdata <= is_misc ? rf_ff[rd] : rf_ff[io_rd];
				dbus_ff.we <= 1'b1;
			end
		end
	end
	assign dbus = dbus_ff;
	always_comb
	begin
		region.direct_io = dbus_ff.addr <= cpuc_pkg::IO_DIR_END;
		region.ext_io = dbus_ff.addr >= cpuc_pkg::EXT_IO_BASE && dbus_ff.addr <= cpuc_pkg::IO_END;
		region.eeprom = dbus_ff.addr >= cpuc_pkg::EE_BASE && dbus_ff.addr <= cpuc_pkg::EE_END;
		region.sram = dbus_ff.addr >= cpuc_pkg::SRAM_BASE;
		if (!(dbus_ff.re || dbus_ff.we))
			region = '0;
	end
	// ****************************************
	// program memory store
	// ****************************************
	assign in_boot = ir_pc_ff >= BOOT_START;
	always_comb
	begin
		if (zval >= BOOT_START)
			tgt_lock = lock.boot_wr | lock.boot_rw;
		else if (zval >= TBL_START)
			tgt_lock = lock.tbl_wr | lock.tbl_rw;
		else
			tgt_lock = lock.app_wr | lock.app_rw;
	end
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			spm_ff <= '0;
			den_ff <= 1'b0;
		end
		else
		begin
			spm_ff.we <= is_misc && sub == cpuc_pkg::MS_SPM && in_boot && !tgt_lock;
			den_ff <= is_misc && sub == cpuc_pkg::MS_SPM && !(in_boot && !tgt_lock);
			if (is_misc && sub == cpuc_pkg::MS_SPM)
			begin
				spm_ff.addr <= zval;
				spm_ff.data <= {rf_ff[5'h01], rf_ff[5'h00]};
			end
		end
	end
	assign store_program_memory_instr = spm_ff;
	assign spm_denied = den_ff;
	// ****************************************
	// checks
	// ****************************************
	chk_pc_advance: assert property (@(posedge sys_clk) disable iff (rst)
		!stall |=> pc_ff == $past(pc_ff) + 16'h0001)
		else $error("pc did not advance on an unstalled cycle");
	chk_alu_writeback: assert property (@(posedge sys_clk) disable iff (rst)
		alu_en |=> rf_ff[$past(alu_rd)] == $past(alu_res))
		else $error("alu result not written back");
	chk_zero_flag: assert property (@(posedge sys_clk) disable iff (rst)
		flag_upd |=> sreg_ff[cpuc_pkg::FL_Z] == ($past(alu_res) == 8'h00))
		else $error("zero flag does not match result");
	chk_mul_two_cyc: assert property (@(posedge sys_clk) disable iff (rst)
		is_mul && !mul_ph_ff |=> mul_ph_ff && stall == 1'b0 ##1 !mul_ph_ff)
		else $error("multiply did not finish in two cycles");
	chk_mul_busy: assert property (@(posedge sys_clk) disable iff (rst)
		mul_busy == mul_ph_ff)
		else $error("multiplier busy out of step with core");
	chk_io_decode: assert property (@(posedge sys_clk) disable iff (rst)
		(dbus_ff.re || dbus_ff.we) && dbus_ff.addr <= cpuc_pkg::IO_END |-> region.direct_io || region.ext_io)
		else $error("i/o address not decoded as i/o");
	chk_direct_io: assert property (@(posedge sys_clk) disable iff (rst)
		ir_vld_ff && op == cpuc_pkg::OP_IO && !ld_ph_ff |=> region.direct_io && !region.ext_io)
		else $error("direct i/o left the first 64 locations");
	chk_eeprom_map: assert property (@(posedge sys_clk) disable iff (rst)
		region.eeprom |-> dbus_ff.addr[15:12] == 4'h1 && !region.sram)
		else $error("eeprom window decoded wrongly");
	chk_sram_base: assert property (@(posedge sys_clk) disable iff (rst)
		(dbus_ff.re || dbus_ff.we) && dbus_ff.addr >= cpuc_pkg::SRAM_BASE |-> region.sram && !region.eeprom)
		else $error("sram not decoded from its base");
	chk_spm_boot: assert property (@(posedge sys_clk) disable iff (rst)
		spm_ff.we |-> $past(ir_pc_ff) >= BOOT_START)
		else $error("program store outside boot section");
	chk_spm_lock: assert property (@(posedge sys_clk) disable iff (rst)
		spm_ff.we |-> !$past(tgt_lock))
		else $error("program store into locked section");
	cov_mul: cover property (@(posedge sys_clk) disable iff (rst) is_mul ##1 mul_ph_ff);
	cov_load: cover property (@(posedge sys_clk) disable iff (rst) ld_ph_ff && region.sram);
	cov_spm: cover property (@(posedge sys_clk) disable iff (rst) spm_ff.we);
	cov_spm_denied: cover property (@(posedge sys_clk) disable iff (rst) den_ff);
endmodule

/* testbench/cpuc_mem_model.sv */
// Purpose: program and data memory model facing the cpu core
// Assumes: program words and load data are answered in the request cycle
// Notes:   program store counters clear on reset
`timescale 1ns/10ps
module cpuc_mem_model (
	input  wire logic                   sys_clk,
	input  wire logic                   rst,
	input  wire logic [15:0]            pm_addr,
	output logic [15:0]                 pm_rdata,
	input  wire cpuc_pkg::cpuc_dbus_s   dbus,
	input  wire cpuc_pkg::cpuc_region_s region,
	output logic [7:0]                  dm_rdata,
	input  wire cpuc_pkg::cpuc_spm_s    store_program_memory_instr,
	input  wire logic                   spm_denied
);
	// ****************************************
	// storage
	// ****************************************
	logic [15:0]            pm [0:255];
	logic [7:0]             dm [0:65535];
	logic [7:0]             idle_pat = 8'h5A;
	cpuc_pkg::cpuc_region_s ld_region;
	int                     spm_ok_cnt;
	int                     spm_deny_cnt;
	logic [31:0]            spm_last;

	assign pm_rdata = pm[pm_addr[7:0]];
	// an idle read bus shows a changing pattern, never the last value
	assign dm_rdata = dbus.re ? dm[dbus.addr] : idle_pat;

	// plain always: the bench preloads dm directly between runs
	always @(posedge sys_clk)
	begin
		idle_pat <= idle_pat + 8'h01;
		if (dbus.we)
			dm[dbus.addr] <= dbus.wdata;
		if (dbus.re)
			ld_region <= region;
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			spm_ok_cnt <= 0;
			spm_deny_cnt <= 0;
			spm_last <= 32'h00000000;
		end
		else
		begin
			if (store_program_memory_instr.we)
				spm_ok_cnt <= spm_ok_cnt + 1;
			if (store_program_memory_instr.we)
				spm_last <= {store_program_memory_instr.addr, store_program_memory_instr.data};
			if (spm_denied)
				spm_deny_cnt <= spm_deny_cnt + 1;
		end
	end
endmodule

/* testbench/cpu_core_alu_multiplier_tb_top.sv */
// Purpose: self-checking bench for the cpu core
// Assumes: programs fit in 256 words
// Notes:   small section bounds keep program store runs short
`timescale 1ns/10ps
module cpu_core_alu_multiplier_tb_top;
	// ****************************************
	// signals
	// ****************************************
	logic                   sys_clk = 1'b0;
	logic                   rst = 1'b1;
	logic [15:0]            pm_addr;
	logic [15:0]            pm_rdata;
	cpuc_pkg::cpuc_dbus_s   dbus;
	cpuc_pkg::cpuc_region_s region;
	logic [7:0]             dm_rdata;
	cpuc_pkg::cpuc_lock_s   lock = '0;
	cpuc_pkg::cpuc_spm_s    store_program_memory_instr;
	logic                   spm_denied;
	logic [7:0]             sreg;
	logic                   insn_done;
	int                     num_errors = 0;
	int                     comparisons = 0;
	int                     pp;
	int                     done;

	always #4 sys_clk = ~sys_clk;

	cpuc_core #(.TBL_START(16'h0008), .BOOT_START(16'h0010)) cpuc_core_inst (.sys_clk(sys_clk), .rst(rst),
		.pm_addr(pm_addr), .pm_rdata(pm_rdata), .dbus(dbus), .region(region), .dm_rdata(dm_rdata),
		.lock(lock), .store_program_memory_instr(store_program_memory_instr), .spm_denied(spm_denied), .sreg(sreg), .insn_done(insn_done));
	cpuc_mem_model cpuc_mem_model_inst (.sys_clk(sys_clk), .rst(rst), .pm_addr(pm_addr), .pm_rdata(pm_rdata),
		.dbus(dbus), .region(region), .dm_rdata(dm_rdata), .store_program_memory_instr(store_program_memory_instr), .spm_denied(spm_denied));

	// ****************************************
	// helpers
	// ****************************************
	task automatic close_out;
		if (num_errors == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp)
		begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
		end
	endtask

	function automatic logic [15:0] ldi(input logic [4:0] r, input logic [7:0] v);
		return {4'hC, r[3:0], v};
	endfunction

	function automatic logic [15:0] outp(input logic [4:0] r, input logic [5:0] a);
		return {4'hB, 1'b1, r, a};
	endfunction

	function automatic logic [15:0] rr(input logic [3:0] op, input logic [1:0] k, input logic [4:0] d,
		input logic [4:0] s);
		return {op, k, d, s};
	endfunction

	task automatic put(input logic [15:0] w);
		cpuc_mem_model_inst.pm[pp] = w;
		pp++;
	endtask

	task automatic new_prog;
		for (int i = 0; i < 256; i++)
			cpuc_mem_model_inst.pm[i] = 16'hC000;
		pp = 0;
	endtask

	task automatic run(input int n);
		rst = 1'b1;
		repeat (2) @(negedge sys_clk);
		rst = 1'b0;
		done = 0;
		repeat (n)
		begin
			@(negedge sys_clk);
			if (insn_done === 1'b1)
				done++;
		end
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic test_alu;
		logic [3:0] op [5] = '{4'h0, 4'h2, 4'h4, 4'h5, 4'hD};
		logic [7:0] a  [5] = '{8'h7F, 8'h00, 8'hF0, 8'h0F, 8'h80};
		logic [7:0] b  [5] = '{8'h01, 8'h01, 8'h0F, 8'hF0, 8'h01};
		logic [7:0] r  [5] = '{8'h80, 8'hFF, 8'h00, 8'hFF, 8'h80};
		logic [7:0] f  [5] = '{8'h2C, 8'h35, 8'h22, 8'h14, 8'h0D};
		for (int i = 0; i < 5; i++)
		begin
			new_prog;
			put(ldi(5'h10, a[i]));
			put(ldi(5'h11, b[i]));
			put(rr(op[i], 2'h0, 5'h10, 5'h11));
			put(outp(5'h10, 6'h05));
			cpuc_mem_model_inst.dm[5] = ~r[i];
			run(10);
			check("alu result", {8'h00, r[i]}, {8'h00, cpuc_mem_model_inst.dm[5]});
			check("status", {8'h00, f[i]}, {8'h00, sreg});
			check("insns done", 16'h000A, done[15:0]);
		end
	endtask

	task automatic test_mul;
		int          pa;
		int          pb;
		logic [15:0] p;
		logic [15:0] e;
		for (int fr = 0; fr < 2; fr++)
			for (int k = 0; k < 3; k++)
			begin
				pa = (k == 0) ? 32'hC0 : -32'h40;
				pb = (k == 1) ? -32'h70 : 32'h90;
				p = 16'(pa * pb);
				e = fr ? {p[14:0], 1'b0} : p;
				{cpuc_mem_model_inst.dm[7], cpuc_mem_model_inst.dm[6]} = ~e;
				new_prog;
				put(ldi(5'h10, 8'hC0));
				put(ldi(5'h11, 8'h90));
				put(rr(fr ? 4'h8 : 4'h7, 2'(k), 5'h10, 5'h11));
				put(outp(5'h00, 6'h06));
				put(outp(5'h01, 6'h07));
				run(10);
				check("product", e, {cpuc_mem_model_inst.dm[7], cpuc_mem_model_inst.dm[6]});
				check("carry", {15'h0000, p[15]}, {15'h0000, sreg[0]});
				check("insns done", 16'h0009, done[15:0]);
			end
	endtask

	task automatic test_decode;
		logic [15:0] ad [7] = '{16'h0003, 16'h003F, 16'h0040, 16'h0FFF, 16'h1000, 16'h1FFF, 16'h2000};
		logic [3:0]  rg [7] = '{4'h8, 4'h8, 4'h4, 4'h4, 4'h2, 4'h2, 4'h1};
		logic [7:0]  v;
		for (int i = 0; i < 7; i++)
		begin
			v = ad[i][7:0] ^ 8'h3C;
			cpuc_mem_model_inst.dm[ad[i]] = ~v;
			cpuc_mem_model_inst.dm[16'h003E] = ~v;
			new_prog;
			put(ldi(5'h1A, ad[i][7:0]));
			put(ldi(5'h1B, ad[i][15:8]));
			put(ldi(5'h12, v));
			put(rr(4'hF, cpuc_pkg::MS_ST, 5'h12, 5'h00));
			put(rr(4'hF, cpuc_pkg::MS_LD, 5'h13, 5'h00));
			put(outp(5'h13, 6'h3E));
			run(12);
			check("stored byte", {8'h00, v}, {8'h00, cpuc_mem_model_inst.dm[ad[i]]});
			check("loaded byte", {8'h00, v}, {8'h00, cpuc_mem_model_inst.dm[16'h003E]});
			check("region", {12'h000, rg[i]}, {12'h000, cpuc_mem_model_inst.ld_region});
		end
	endtask

	task automatic test_word;
		new_prog;
		put(ldi(5'h18, 8'h02));
		put(ldi(5'h19, 8'h00));
		put(16'hE105);
		put(outp(5'h18, 6'h08));
		put(outp(5'h19, 6'h09));
		run(10);
		check("word result", 16'hFFFD, {cpuc_mem_model_inst.dm[9], cpuc_mem_model_inst.dm[8]});
		check("word flags", 16'h0015, {8'h00, sreg});
	endtask

	task automatic test_spm;
		logic [15:0] z [3] = '{16'h0004, 16'h000A, 16'h0014};
		logic        deny;
		for (int s = 0; s < 3; s++)
			for (int b = 0; b < 7; b++)
			begin
				deny = (b < 6) && ((5 - b) / 2 == s);
				lock = (b < 6) ? cpuc_pkg::cpuc_lock_s'(6'h01 << b) : '0;
				new_prog;
				put(ldi(5'h10, 8'h12));
				put(ldi(5'h11, 8'h34));
				put(rr(4'h7, 2'h0, 5'h10, 5'h11));
				put(ldi(5'h1E, z[s][7:0]));
				put(ldi(5'h1F, z[s][15:8]));
				put(rr(4'hF, cpuc_pkg::MS_SPM, 5'h00, 5'h00));
				pp = 16;
				put(rr(4'hF, cpuc_pkg::MS_SPM, 5'h00, 5'h00));
				run(24);
				check("refusals", 16'(1 + deny), 16'(cpuc_mem_model_inst.spm_deny_cnt));
				check("stores", {15'h0000, !deny}, 16'(cpuc_mem_model_inst.spm_ok_cnt));
				check("store addr", deny ? 16'h0000 : z[s], cpuc_mem_model_inst.spm_last[31:16]);
				check("store data", deny ? 16'h0000 : 16'h03A8, cpuc_mem_model_inst.spm_last[15:0]);
			end
	endtask

	// ****************************************
	// sequence and watchdog
	// ****************************************
	initial
	begin
		repeat (16) @(negedge sys_clk);
		test_alu;
		test_mul;
		test_decode;
		test_word;
		test_spm;
		close_out;
	end

	initial
	begin
		repeat (5000) @(posedge sys_clk);
		num_errors++;
		close_out;
	end
endmodule
